// >>> ids_exec.sv
// Purpose: execute stage for a few file/branch instructions
// Assumes: file_rdata is the addressed register, same cycle as insn
// Notes:   core owns fetch and pc increment; this block only redirects
`include "ids_params.svh"
`timescale 1ns/1ps
module ids_exec (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    ce,
  input  wire logic                    insn_valid,
  input  wire logic [`IDS_INSN_W-1:0]  insn,
  input  wire logic [`IDS_DATA_W-1:0]  file_rdata,
  input  wire logic [`IDS_DATA_W-1:0]  program_page_latch,
  output logic      [`IDS_FADDR_W-1:0] file_addr,
  output logic                         file_we,
  output logic      [`IDS_DATA_W-1:0]  file_wdata,
  output logic                         w_we,
  output logic      [`IDS_DATA_W-1:0]  w_wdata,
  output logic                         zero_we,
  output logic                         zero_val,
  output logic                         pc_load,
  output logic      [`IDS_PC_W-1:0]    pc_target,
  output logic                         nop_slot
);
  ids_pkg::ids_kind_t kind;
  ids_pkg::ids_state_t state, next_state;
  logic [`IDS_FADDR_W-1:0] next_file_addr;
  logic                    next_file_we, next_w_we, next_zero_we, next_zero_val;
  logic                    next_pc_load, next_nop_slot;
  logic [`IDS_DATA_W-1:0]  next_file_wdata, next_w_wdata;
  logic [`IDS_PC_W-1:0]    next_pc_target;
  logic [`IDS_DATA_W-1:0]  result;
  logic                    dest_file, live;

  ids_decode u_dec (
    .insn (insn),
    .kind (kind)
  );

  // natural 8-bit truncation gives the wrap
  function automatic logic [`IDS_DATA_W-1:0] step(input logic [`IDS_DATA_W-1:0] v, input logic up);
    step = up ? v + `IDS_ONE_BYTE : v - `IDS_ONE_BYTE;
  endfunction : step

  assign dest_file = insn[`IDS_DEST_BIT];
  // the slot after a skip or branch is squashed whatever it holds
  assign live      = insn_valid && state == ids_pkg::IDS_EXEC;

  always_comb begin
    next_state      = ids_pkg::IDS_EXEC;
    next_file_addr  = insn[`IDS_FADDR_W-1:0];
    next_file_we    = 1'b0;
    next_file_wdata = file_wdata;
    next_w_we       = 1'b0;
    next_w_wdata    = w_wdata;
    next_zero_we    = 1'b0;
    next_zero_val   = zero_val;
    next_pc_load    = 1'b0;
    next_pc_target  = pc_target;
    next_nop_slot   = !live && insn_valid;
    result          = step(file_rdata, kind == ids_pkg::IDS_K_INCREMENT_SKIP_ZERO_OP);
    if (live) begin
      unique case (kind)
        ids_pkg::IDS_K_DECREMENT_FILE_OP,
        ids_pkg::IDS_K_DECREMENT_SKIP_ZERO_OP,
        ids_pkg::IDS_K_INCREMENT_SKIP_ZERO_OP: begin
          next_file_we    = dest_file;
          next_file_wdata = result;
          next_w_we       = !dest_file;
          next_w_wdata    = result;
          if (kind == ids_pkg::IDS_K_DECREMENT_FILE_OP) begin
            next_zero_we  = 1'b1;
            next_zero_val = result == `IDS_ZERO_BYTE;
          end else if (result == `IDS_ZERO_BYTE) begin
            next_state    = ids_pkg::IDS_FLUSH;
          end
        end
        ids_pkg::IDS_K_CLEAR_WORKING_OP: begin
          next_w_we     = 1'b1;
          next_w_wdata  = `IDS_ZERO_BYTE;
          next_zero_we  = 1'b1;
          next_zero_val = 1'b1;
        end
        ids_pkg::IDS_K_UNCONDITIONAL_BRANCH_OP: begin
          next_pc_load   = 1'b1;
          next_pc_target = {program_page_latch[`IDS_PAGE_HI:`IDS_PAGE_LO],
                            insn[`IDS_LIT_W-1:0]};
          next_state     = ids_pkg::IDS_FLUSH;
        end
        ids_pkg::IDS_K_NONE: begin
        end
      endcase
    end else if (state == ids_pkg::IDS_FLUSH && !insn_valid) begin
      next_state = ids_pkg::IDS_FLUSH;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state      <= ids_pkg::IDS_EXEC;
      file_addr  <= '0;
      file_we    <= 1'b0;
      file_wdata <= '0;
      w_we       <= 1'b0;
      w_wdata    <= '0;
      zero_we    <= 1'b0;
      zero_val   <= 1'b0;
      pc_load    <= 1'b0;
      pc_target  <= '0;
      nop_slot   <= 1'b0;
    end else if (ce) begin
      state      <= next_state;
      file_addr  <= next_file_addr;
      file_we    <= next_file_we;
      file_wdata <= next_file_wdata;
      w_we       <= next_w_we;
      w_wdata    <= next_w_wdata;
      zero_we    <= next_zero_we;
      zero_val   <= next_zero_val;
      pc_load    <= next_pc_load;
      pc_target  <= next_pc_target;
      nop_slot   <= next_nop_slot;
    end
  end

  property p_dec_file_zero;
    @(posedge clk) disable iff (reset)
      (ce && live && kind == ids_pkg::IDS_K_DECREMENT_FILE_OP) |=>
        zero_we && zero_val == ($past(file_rdata) == `IDS_ONE_BYTE);
  endproperty
  a_dec_file_zero: assert property (p_dec_file_zero) else $error("decrement zero flag wrong");

  property p_dec_file_route;
    @(posedge clk) disable iff (reset)
      (ce && live && kind == ids_pkg::IDS_K_DECREMENT_FILE_OP) |=>
        (file_we != w_we) && (file_we == $past(dest_file))
        && (file_we ? file_wdata : w_wdata) == $past(file_rdata) - `IDS_ONE_BYTE;
  endproperty
  a_dec_file_route: assert property (p_dec_file_route) else $error("decrement result misrouted");

  property p_clear_w;
    @(posedge clk) disable iff (reset)
      (ce && live && kind == ids_pkg::IDS_K_CLEAR_WORKING_OP) |=>
        w_we && w_wdata == `IDS_ZERO_BYTE && zero_we && zero_val && !file_we;
  endproperty
  a_clear_w: assert property (p_clear_w) else $error("clear W wrong");

  property p_skip_noflag;
    @(posedge clk) disable iff (reset)
      (ce && live && (kind == ids_pkg::IDS_K_DECREMENT_SKIP_ZERO_OP
                      || kind == ids_pkg::IDS_K_INCREMENT_SKIP_ZERO_OP)) |=> !zero_we;
  endproperty
  a_skip_noflag: assert property (p_skip_noflag) else $error("skip op touched flag");

  sequence s_dec_zero;
    ce && live && kind == ids_pkg::IDS_K_DECREMENT_SKIP_ZERO_OP && file_rdata == `IDS_ONE_BYTE;
  endsequence
  sequence s_inc_zero;
    ce && live && kind == ids_pkg::IDS_K_INCREMENT_SKIP_ZERO_OP && file_rdata == `IDS_ALL_ONES;
  endsequence
  // the word offered right after a zero skip is the one that must vanish
  sequence s_squash;
    ce && insn_valid;
  endsequence
  property p_dec_skip;
    @(posedge clk) disable iff (reset)
      s_dec_zero ##1 s_squash |=> nop_slot && !file_we && !w_we && !zero_we;
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("zero decrement did not squash next word");

  property p_dec_skip_flush;
    @(posedge clk) disable iff (reset)
      s_dec_zero |=> state == ids_pkg::IDS_FLUSH;
  endproperty
  a_dec_skip_flush: assert property (p_dec_skip_flush) else $error("zero decrement did not skip");

  property p_inc_wrap_skip;
    @(posedge clk) disable iff (reset)
      s_inc_zero |=>
        state == ids_pkg::IDS_FLUSH && (file_we ? file_wdata : w_wdata) == `IDS_ZERO_BYTE;
  endproperty
  a_inc_wrap_skip: assert property (p_inc_wrap_skip) else $error("increment wrap did not skip");

  property p_inc_skip;
    @(posedge clk) disable iff (reset)
      s_inc_zero ##1 s_squash |=> nop_slot && !file_we && !w_we && !zero_we;
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("zero increment did not squash next word");

  property p_inc_noskip;
    @(posedge clk) disable iff (reset)
      (ce && live && kind == ids_pkg::IDS_K_INCREMENT_SKIP_ZERO_OP && file_rdata != `IDS_ALL_ONES) |=>
        state == ids_pkg::IDS_EXEC;
  endproperty
  a_inc_noskip: assert property (p_inc_noskip) else $error("increment skipped wrongly");

  property p_branch;
    @(posedge clk) disable iff (reset)
      (ce && live && kind == ids_pkg::IDS_K_UNCONDITIONAL_BRANCH_OP) |=>
        pc_load && !zero_we
        && pc_target == {$past(program_page_latch[`IDS_PAGE_HI:`IDS_PAGE_LO]), $past(insn[`IDS_LIT_W-1:0])};
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");

  property p_branch_two;
    @(posedge clk) disable iff (reset)
      (ce && live && kind == ids_pkg::IDS_K_UNCONDITIONAL_BRANCH_OP) ##1 s_squash |=> nop_slot && !pc_load;
  endproperty
  a_branch_two: assert property (p_branch_two) else $error("branch not two cycles");

  property p_unhandled_quiet;
    @(posedge clk) disable iff (reset)
      (ce && live && kind == ids_pkg::IDS_K_NONE) |=>
        !file_we && !w_we && !zero_we && !pc_load && state == ids_pkg::IDS_EXEC;
  endproperty
  a_unhandled_quiet: assert property (p_unhandled_quiet) else $error("unhandled word produced output");

  // a frozen cycle must leave every strobe as it was, not just skip new work
  property p_freeze;
    @(posedge clk) disable iff (reset)
      !ce |=> $stable(file_we) && $stable(w_we) && $stable(zero_we) && $stable(pc_load) && $stable(nop_slot);
  endproperty
  a_freeze: assert property (p_freeze) else $error("strobes moved while clock enable low");
endmodule : ids_exec

// >>> ids_params.svh
// Purpose: constants for the inc/dec/skip/branch execution block
// Assumes: 14-bit instruction words, 15-bit program counter
// Notes:   encodings follow the usual 14-bit core opcode map
`ifndef IDS_PARAMS_SVH
`define IDS_PARAMS_SVH
`define IDS_INSN_W        14
`define IDS_PC_W          15
`define IDS_DATA_W        8
`define IDS_FADDR_W       7
`define IDS_LIT_W         11
`define IDS_DEST_BIT      7
`define IDS_OP_HI         13
`define IDS_OP6_LO        8
`define IDS_OP3_LO        11
`define IDS_OP6_DECREMENT_FILE_OP       6'h03
`define IDS_OP6_DECREMENT_SKIP_ZERO_OP  6'h0B
`define IDS_OP6_INCREMENT_SKIP_ZERO_OP  6'h0F
`define IDS_OP3_UNCONDITIONAL_BRANCH_OP 3'h5
`define IDS_CLEAR_WORKING_WORD          14'h0100
`define IDS_CLEAR_WORKING_MASK          14'h3F80
`define IDS_ZERO_BYTE     8'h00
`define IDS_ONE_BYTE      8'h01
`define IDS_ALL_ONES      8'hFF
`define IDS_PAGE_HI       6
`define IDS_PAGE_LO       3
`define IDS_CLK_PERIOD_NS 5
`endif

// >>> ids_pkg.sv
// Purpose: types for the inc/dec/skip/branch execution block
// Assumes: nothing beyond the params header
// Notes:   states of the two-cycle sequencer
package ids_pkg;
  typedef enum logic [0:0] {
    IDS_EXEC,
    IDS_FLUSH
  } ids_state_t;

  typedef enum logic [2:0] {
    IDS_K_NONE,
    IDS_K_DECREMENT_FILE_OP,
    IDS_K_CLEAR_WORKING_OP,
    IDS_K_DECREMENT_SKIP_ZERO_OP,
    IDS_K_INCREMENT_SKIP_ZERO_OP,
    IDS_K_UNCONDITIONAL_BRANCH_OP
  } ids_kind_t;
endpackage : ids_pkg

// >>> ids_decode.sv
// Purpose: classify an instruction word into the handled kinds
// Assumes: word is stable for the cycle it is presented
// Notes:   purely combinational
`include "ids_params.svh"
`timescale 1ns/1ps
module ids_decode (
  input  wire logic [`IDS_INSN_W-1:0] insn,
  output ids_pkg::ids_kind_t          kind
);
  always_comb begin
    kind = ids_pkg::IDS_K_NONE;
    if ((insn & `IDS_CLEAR_WORKING_MASK) == `IDS_CLEAR_WORKING_WORD)
      kind = ids_pkg::IDS_K_CLEAR_WORKING_OP;
    else if (insn[`IDS_OP_HI:`IDS_OP3_LO] == `IDS_OP3_UNCONDITIONAL_BRANCH_OP)
      kind = ids_pkg::IDS_K_UNCONDITIONAL_BRANCH_OP;
    else if (insn[`IDS_OP_HI:`IDS_OP6_LO] == `IDS_OP6_DECREMENT_FILE_OP)
      kind = ids_pkg::IDS_K_DECREMENT_FILE_OP;
    else if (insn[`IDS_OP_HI:`IDS_OP6_LO] == `IDS_OP6_DECREMENT_SKIP_ZERO_OP)
      kind = ids_pkg::IDS_K_DECREMENT_SKIP_ZERO_OP;
    else if (insn[`IDS_OP_HI:`IDS_OP6_LO] == `IDS_OP6_INCREMENT_SKIP_ZERO_OP)
      kind = ids_pkg::IDS_K_INCREMENT_SKIP_ZERO_OP;
  end
endmodule : ids_decode

// >>> ids_exec_tb.sv
// Purpose: self-checking bench for the inc/dec/skip/branch execute block
// Assumes: outputs land on the same edge that takes a word
// Notes:   table rows for plain cases, hand tests for reset, ce and back-to-back
`include "ids_params.svh"
`timescale 1ns/1ps
module ids_exec_tb;
  typedef struct {
    logic [13:0] insn;
    logic [7:0]  rd;
    logic [7:0]  pl;
    logic        fwe;
    logic        wwe;
    logic [7:0]  res;
    logic        zwe;
    logic        zv;
    logic        pcl;
    logic [14:0] pct;
    logic        skip;
  } ids_row_t;

  logic                    clk;
  logic                    reset;
  logic                    ce;
  logic                    insn_valid;
  logic [`IDS_INSN_W-1:0]  insn;
  logic [`IDS_DATA_W-1:0]  file_rdata;
  logic [`IDS_DATA_W-1:0]  program_page_latch;
  logic [`IDS_FADDR_W-1:0] file_addr;
  logic                    file_we;
  logic [`IDS_DATA_W-1:0]  file_wdata;
  logic                    w_we;
  logic [`IDS_DATA_W-1:0]  w_wdata;
  logic                    zero_we;
  logic                    zero_val;
  logic                    pc_load;
  logic [`IDS_PC_W-1:0]    pc_target;
  logic                    nop_slot;
  int                      error_cnt = 0;
  int                      total_checks = 0;
  int                      cycles = 0;
  ids_row_t                rows [11];

  ids_exec dut (
    .clk(clk), .reset(reset), .ce(ce), .insn_valid(insn_valid), .insn(insn),
    .file_rdata(file_rdata), .program_page_latch(program_page_latch),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .w_we(w_we),
    .w_wdata(w_wdata), .zero_we(zero_we), .zero_val(zero_val), .pc_load(pc_load),
    .pc_target(pc_target), .nop_slot(nop_slot)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("errors=%0d checks=%0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  // one word presented for one cycle, outputs sampled mid-cycle after the take
  task automatic issue(input logic [13:0] w, input logic [7:0] rd, input logic [7:0] pl);
    @(posedge clk);
    insn <= w;
    file_rdata <= rd;
    program_page_latch <= pl;
    insn_valid <= 1'b1;
    @(posedge clk);
    insn_valid <= 1'b0;
    @(negedge clk);
  endtask : issue

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    insn_valid = 1'b0;
    insn = 14'h0000;
    file_rdata = 8'h00;
    program_page_latch = 8'h00;
    rows[0] = '{14'h03A5, 8'h10, 8'h00, 1, 0, 8'h0F, 1, 0, 0, 15'h0000, 0};
    rows[1] = '{14'h0325, 8'h01, 8'h00, 0, 1, 8'h00, 1, 1, 0, 15'h0000, 0};
    rows[2] = '{14'h0325, 8'h00, 8'h00, 0, 1, 8'hFF, 1, 0, 0, 15'h0000, 0};
    rows[3] = '{14'h0100, 8'h5A, 8'h00, 0, 1, 8'h00, 1, 1, 0, 15'h0000, 0};
    rows[4] = '{14'h0BA5, 8'h05, 8'h00, 1, 0, 8'h04, 0, 0, 0, 15'h0000, 0};
    rows[5] = '{14'h0B25, 8'h01, 8'h00, 0, 1, 8'h00, 0, 0, 0, 15'h0000, 1};
    rows[6] = '{14'h0FA5, 8'hFF, 8'h00, 1, 0, 8'h00, 0, 0, 0, 15'h0000, 1};
    rows[7] = '{14'h0F25, 8'h41, 8'h00, 0, 1, 8'h42, 0, 0, 0, 15'h0000, 0};
    rows[8] = '{14'h2FFF, 8'h00, 8'h78, 0, 0, 8'h00, 0, 0, 1, 15'h7FFF, 1};
    rows[9] = '{14'h2955, 8'h00, 8'hC8, 0, 0, 8'h00, 0, 0, 1, 15'h4955, 1};
    // unhandled word: nothing may move
    rows[10] = '{14'h0725, 8'h10, 8'h00, 0, 0, 8'h00, 0, 0, 0, 15'h0000, 0};
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk({file_we, w_we, zero_we, pc_load, nop_slot}, 15'h0000);
    for (int i = 0; i < 11; i++) begin
      issue(rows[i].insn, rows[i].rd, rows[i].pl);
      chk(file_we, rows[i].fwe);
      chk(w_we, rows[i].wwe);
      if (rows[i].fwe) chk({file_addr, file_wdata}, {7'h25, rows[i].res});
      if (rows[i].wwe) chk(w_wdata, rows[i].res);
      chk(zero_we, rows[i].zwe);
      if (rows[i].zwe) chk(zero_val, rows[i].zv);
      chk(pc_load, rows[i].pcl);
      if (rows[i].pcl) chk(pc_target, rows[i].pct);
      chk(nop_slot, 1'b0);
      // the word after a skip or branch must vanish
      if (rows[i].skip) begin
        issue(14'h0325, 8'h33, 8'h00);
        chk({file_we, w_we, zero_we, nop_slot}, 15'h0001);
      end
    end
    // ce low must freeze, then the held word is taken once ce returns
    @(posedge clk);
    ce <= 1'b0;
    issue(14'h0325, 8'h80, 8'h00);
    chk(w_we, 1'b0);
    @(posedge clk);
    insn_valid <= 1'b1;
    ce <= 1'b1;
    @(posedge clk);
    insn_valid <= 1'b0;
    @(negedge clk);
    chk({w_we, w_wdata}, {1'b1, 8'h7F});
    // branch followed at once by a word, no idle gap
    @(posedge clk);
    insn <= 14'h2800;
    program_page_latch <= 8'h08;
    insn_valid <= 1'b1;
    @(posedge clk);
    insn <= 14'h0100;
    @(negedge clk);
    chk({pc_load, pc_target}, {1'b1, 15'h0800});
    @(posedge clk);
    insn_valid <= 1'b0;
    @(negedge clk);
    chk({w_we, pc_load, nop_slot}, 15'h0001);
    // zero skips with the next word right behind them, no idle gap
    @(posedge clk);
    insn <= 14'h0B25;
    file_rdata <= 8'h01;
    insn_valid <= 1'b1;
    @(posedge clk);
    insn <= 14'h0100;
    @(negedge clk);
    chk({w_we, w_wdata, zero_we}, {1'b1, 8'h00, 1'b0});
    @(posedge clk);
    insn <= 14'h0FA5;
    file_rdata <= 8'hFF;
    @(negedge clk);
    chk({w_we, zero_we, nop_slot}, 16'h0001);
    @(posedge clk);
    insn <= 14'h0325;
    @(negedge clk);
    chk({file_we, file_wdata, zero_we}, {1'b1, 8'h00, 1'b0});
    @(posedge clk);
    insn_valid <= 1'b0;
    @(negedge clk);
    chk({file_we, w_we, nop_slot}, 16'h0001);
    // reset in mid-flush must drop the pending squash
    @(posedge clk);
    insn <= 14'h2800;
    insn_valid <= 1'b1;
    @(posedge clk);
    insn_valid <= 1'b0;
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk({pc_load, nop_slot}, 16'h0000);
    issue(14'h0325, 8'h80, 8'h00);
    chk({w_we, w_wdata, nop_slot}, {1'b1, 8'h7F, 1'b0});
    stop_test();
  end
endmodule : ids_exec_tb
